// *** mcx_exec.sv ***
// execution of call, byte clear, bit clear, watchdog clear and invert
// assumes operand byte arrives with the instruction and memory writes
// complete at the clock edge after memWrEn is seen
`timescale 1ns/1ps
`include "mcx_params.svh"

module mcx_exec #(
    parameter logic [`MCX_WDOG_W-1:0] WDOG_TERMINAL = `MCX_WDOG_TERM_DEF
) (
    input wire logic clk,
    input wire logic reset,
    // axi4-lite register port
    input wire logic [`MCX_AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`MCX_AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // instruction issue from the decoder
    input wire logic instrValid,
    input wire mcx_pkg::mcx_op_t instrOp,
    input wire logic [`MCX_ADDR_W-1:0] instrAddr,
    input wire logic [`MCX_BIT_W-1:0] instrBit,
    input wire logic [`MCX_PC_W-1:0] instrTarget,
    input wire logic [`MCX_DATA_W-1:0] instrOperand,
    input wire logic [`MCX_PC_W-1:0] pcValue,
    input wire logic sleepReq,
    output logic instrReady,
    // data memory, stack and program counter
    output logic memWrEn,
    output logic [`MCX_ADDR_W-1:0] memWrAddr,
    output logic [`MCX_DATA_W-1:0] memWrData,
    output logic stackPush,
    output logic [`MCX_PC_W-1:0] stackData,
    output logic pcLoad,
    output logic [`MCX_PC_W-1:0] pcTarget,
    // status flags
    output logic zeroFlag,
    output logic timeoutFlag,
    output logic powerDownFlag,
    output logic [`MCX_WDOG_W-1:0] watchdogCounter
);
    // =================================================================
    // state
    mcx_pkg::mcx_state_t state_reg;
    mcx_pkg::mcx_state_t state_next;
    logic ready_reg;
    logic [`MCX_PC_W-1:0] target_reg;
    logic memWrEn_reg;
    logic [`MCX_ADDR_W-1:0] memWrAddr_reg;
    logic [`MCX_DATA_W-1:0] memWrData_reg;
    logic stackPush_reg;
    logic [`MCX_PC_W-1:0] stackData_reg;
    logic pcLoad_reg;
    logic [`MCX_PC_W-1:0] pcTarget_reg;
    logic zero_reg;
    logic timeout_reg;
    logic pdown_reg;
    logic [`MCX_WDOG_W-1:0] wdog_reg;
    logic wdogEn_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [`MCX_AXI_AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    logic accept;
    logic isCall;
    logic isWdogClear;
    logic wdogWrap;
    logic doWrite;

    mcx_res_if res ();

    mcx_result_unit u_result (
        .res(res)
    );

    // =================================================================
    // decode of the accepted instruction
    assign accept = instrValid && ready_reg;
    assign isCall = accept && (instrOp == mcx_pkg::MCX_OP_CALL);
    assign isWdogClear = accept && (instrOp == mcx_pkg::MCX_OP_CLEARWDOG);
    assign res.op = instrOp;
    assign res.operand = instrOperand;
    assign res.bitSel = instrBit;

    // call holds the core for a second cycle, all others return at once
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            mcx_pkg::MCX_ST_IDLE: begin
                if (isCall) begin
                    state_next = mcx_pkg::MCX_ST_JUMP; // [RULE3]
                end
            end
            mcx_pkg::MCX_ST_JUMP: begin
                state_next = mcx_pkg::MCX_ST_IDLE; // [RULE3] [RULE10]
            end
        endcase
    end

    // sequencer state and issue ready, registered to keep outputs clean
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= mcx_pkg::MCX_ST_IDLE;
            ready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == mcx_pkg::MCX_ST_IDLE);
        end
    end

    // =================================================================
    // call: push return address, then load target next cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            stackPush_reg <= 1'b0;
            stackData_reg <= '0;
            target_reg <= '0;
            pcLoad_reg <= 1'b0;
            pcTarget_reg <= '0;
        end else begin
            stackPush_reg <= isCall;
            pcLoad_reg <= (state_reg == mcx_pkg::MCX_ST_JUMP); // [RULE2]
            if (isCall) begin
                stackData_reg <= pcValue + `MCX_PC_STEP; // [RULE1]
                target_reg <= instrTarget;
            end
            if (state_reg == mcx_pkg::MCX_ST_JUMP) begin
                pcTarget_reg <= target_reg; // [RULE2]
            end
        end
    end

    // =================================================================
    // data memory write-back in the cycle after issue
    always_ff @(posedge clk) begin
        if (reset) begin
            memWrEn_reg <= 1'b0;
            memWrAddr_reg <= '0;
            memWrData_reg <= '0;
        end else begin
            memWrEn_reg <= accept && res.writes; // [RULE4] [RULE5] [RULE7] [RULE10]
            if (accept && res.writes) begin
                memWrAddr_reg <= instrAddr;
                memWrData_reg <= res.result;
            end
        end
    end

    // zero flag follows invert only; every other op leaves it alone
    always_ff @(posedge clk) begin
        if (reset) begin
            zero_reg <= 1'b0;
        end else if (accept && instrOp == mcx_pkg::MCX_OP_INVERT) begin
            zero_reg <= res.zero; // [RULE8] [RULE9]
        end
    end

    // =================================================================
    // watchdog counter; a wrap in the clearing cycle still sets timeout
    assign wdogWrap = wdogEn_reg && (wdog_reg == WDOG_TERMINAL);

    always_ff @(posedge clk) begin
        if (reset) begin
            wdog_reg <= `MCX_WDOG_ZERO;
        end else if (isWdogClear || wdogWrap) begin
            wdog_reg <= `MCX_WDOG_ZERO; // [RULE6]
        end else if (wdogEn_reg) begin
            wdog_reg <= wdog_reg + `MCX_WDOG_STEP;
        end
    end

    // set beats clear so no timeout or sleep event is lost
    always_ff @(posedge clk) begin
        if (reset) begin
            timeout_reg <= 1'b0;
            pdown_reg <= 1'b0;
        end else begin
            if (wdogWrap) begin
                timeout_reg <= 1'b1;
            end else if (isWdogClear) begin
                timeout_reg <= 1'b0; // [RULE6]
            end
            if (sleepReq) begin
                pdown_reg <= 1'b1;
            end else if (isWdogClear) begin
                pdown_reg <= 1'b0; // [RULE6]
            end
        end
    end

    // =================================================================
    // axi4-lite write: address and data taken in either order
    assign doWrite = !awready_reg && !wready_reg && !bvalid_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (bvalid_reg && s_axi_bready) begin
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // register update and write response
    always_ff @(posedge clk) begin
        if (reset) begin
            wdogEn_reg <= `MCX_CTRL_RESET;
            bvalid_reg <= 1'b0;
            bresp_reg <= `MCX_RESP_OKAY;
        end else if (doWrite) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= `MCX_RESP_OKAY;
            unique case (awaddr_reg)
                `MCX_REG_CONTROL: begin
                    if (wstrb_reg[0]) begin
                        wdogEn_reg <= wdata_reg[`MCX_CTRL_WDOG_EN];
                    end
                end
                // read-only words ignore writes but answer okay
                `MCX_REG_STATUS, `MCX_REG_WDOG, `MCX_REG_RETADDR: begin
                    bresp_reg <= `MCX_RESP_OKAY;
                end
                default: begin
                    bresp_reg <= `MCX_RESP_DECERR;
                end
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // =================================================================
    // axi4-lite read, one outstanding at a time
    always_ff @(posedge clk) begin
        if (reset) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= `MCX_WORD_ZERO;
            rresp_reg <= `MCX_RESP_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= `MCX_WORD_ZERO;
            rresp_reg <= `MCX_RESP_OKAY;
            unique case (s_axi_araddr)
                `MCX_REG_CONTROL: rdata_reg[`MCX_CTRL_WDOG_EN] <= wdogEn_reg;
                `MCX_REG_STATUS: begin
                    rdata_reg[`MCX_STAT_ZERO] <= zero_reg;
                    rdata_reg[`MCX_STAT_TIMEOUT] <= timeout_reg;
                    rdata_reg[`MCX_STAT_PDOWN] <= pdown_reg;
                    rdata_reg[`MCX_STAT_BUSY] <= !ready_reg;
                end
                `MCX_REG_WDOG: rdata_reg[`MCX_WDOG_W-1:0] <= wdog_reg;
                `MCX_REG_RETADDR: rdata_reg[`MCX_PC_W-1:0] <= stackData_reg;
                default: rresp_reg <= `MCX_RESP_DECERR;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // =================================================================
    // outputs straight from flip-flops
    assign instrReady = ready_reg;
    assign memWrEn = memWrEn_reg;
    assign memWrAddr = memWrAddr_reg;
    assign memWrData = memWrData_reg;
    assign stackPush = stackPush_reg;
    assign stackData = stackData_reg;
    assign pcLoad = pcLoad_reg;
    assign pcTarget = pcTarget_reg;
    assign zeroFlag = zero_reg;
    assign timeoutFlag = timeout_reg;
    assign powerDownFlag = pdown_reg;
    assign watchdogCounter = wdog_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // =================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_call_push_ret: assert property (isCall |=> stackPush && stackData == $past(pcValue) + `MCX_PC_STEP) // [RULE1]
        else $error("call did not push pc plus one");
    a_call_load_pc: assert property (isCall |=> !pcLoad ##1 pcLoad && pcTarget == $past(instrTarget, 2)) // [RULE2]
        else $error("call did not load target");
    a_call_two_cyc: assert property (isCall |=> !instrReady ##1 instrReady) // [RULE3]
        else $error("call did not take two cycles");
    a_byte_clear: assert property (accept && instrOp == mcx_pkg::MCX_OP_CLEARBYTE |=> // [RULE4]
        memWrEn && memWrData == `MCX_BYTE_ZERO && memWrAddr == $past(instrAddr))
        else $error("byte clear wrote nonzero");
    a_bit_clear: assert property (accept && instrOp == mcx_pkg::MCX_OP_CLEARBIT |=> // [RULE5]
        memWrEn && memWrData == ($past(instrOperand) & ~(`MCX_BIT_ONE << $past(instrBit))))
        else $error("bit clear touched wrong bits");
    a_wdog_clear: assert property (isWdogClear && !sleepReq && !wdogWrap |=> // [RULE6]
        watchdogCounter == `MCX_WDOG_ZERO && !timeoutFlag && !powerDownFlag)
        else $error("watchdog clear left state set");
    a_invert_data: assert property (accept && instrOp == mcx_pkg::MCX_OP_INVERT |=> // [RULE7]
        memWrEn && memWrData == ~$past(instrOperand) && memWrAddr == $past(instrAddr))
        else $error("invert wrote wrong byte");
    a_zero_only_inv: assert property (!(accept && instrOp == mcx_pkg::MCX_OP_INVERT) |=> $stable(zeroFlag)) // [RULE8]
        else $error("zero flag moved without invert");
    a_zero_value: assert property (accept && instrOp == mcx_pkg::MCX_OP_INVERT |=> // [RULE9]
        zeroFlag == ($past(instrOperand) == {`MCX_DATA_W{1'b1}}))
        else $error("zero flag wrong after invert");
    a_single_cycle: assert property (accept && !isCall |=> instrReady) // [RULE10]
        else $error("single-cycle op stalled issue");
endmodule

// *** mcx_params.svh ***
// constants for the call / clear / invert execution block
// assumes a 20 MHz core clock and an axi4-lite register port
//
// Contract
// [RULE1] call pushes program counter plus one
// [RULE2] call then loads target, flags unchanged
// [RULE3] call takes two instruction cycles
// [RULE4] byte clear writes zero, flags unchanged
// [RULE5] bit clear zeroes one bit only
// [RULE6] watchdog clear zeroes counter and both flags; a wrap or sleep request in the same cycle still sets its flag
// [RULE7] invert writes complemented byte back
// [RULE8] invert changes only the zero flag
// [RULE9] zero flag set when inverted result zero
// [RULE10] other four instructions take one cycle
`ifndef MCX_PARAMS_SVH
`define MCX_PARAMS_SVH

// =====================================================================
// widths
`define MCX_DATA_W 8
`define MCX_ADDR_W 8
`define MCX_BIT_W 3
`define MCX_PC_W 13
`define MCX_WDOG_W 16
`define MCX_AXI_AW 4

// =====================================================================
// data values
`define MCX_BYTE_ZERO 8'h00
`define MCX_BIT_ONE 8'h01
`define MCX_PC_STEP 13'h0001
`define MCX_WDOG_ZERO 16'h0000
`define MCX_WDOG_STEP 16'h0001
`define MCX_WDOG_TERM_DEF 16'hffff

// =====================================================================
// register map (byte addresses) and fields
`define MCX_REG_CONTROL 4'h0
`define MCX_REG_STATUS 4'h4
`define MCX_REG_WDOG 4'h8
`define MCX_REG_RETADDR 4'hc
`define MCX_CTRL_WDOG_EN 0
`define MCX_STAT_ZERO 0
`define MCX_STAT_TIMEOUT 1
`define MCX_STAT_PDOWN 2
`define MCX_STAT_BUSY 3
`define MCX_CTRL_RESET 1'b0
`define MCX_RESP_OKAY 2'h0
`define MCX_RESP_DECERR 2'h3
`define MCX_WORD_ZERO 32'h0000_0000

`endif

// *** mcx_pkg.sv ***
// types for the call / clear / invert execution block
// assumes mcx_params.svh supplies the widths
`include "mcx_params.svh"

package mcx_pkg;
    // =================================================================
    // instruction group decoded upstream
    typedef enum logic [2:0] {
        MCX_OP_CALL,
        MCX_OP_CLEARBYTE,
        MCX_OP_CLEARBIT,
        MCX_OP_CLEARWDOG,
        MCX_OP_INVERT
    } mcx_op_t;

    // =================================================================
    // sequencing of the two-cycle call
    typedef enum logic {
        MCX_ST_IDLE,
        MCX_ST_JUMP
    } mcx_state_t;
endpackage

// *** mcx_res_if.sv ***
// carrier between the sequencer and the data result unit
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
`include "mcx_params.svh"

interface mcx_res_if;
    mcx_pkg::mcx_op_t op;
    logic [`MCX_DATA_W-1:0] operand;
    logic [`MCX_BIT_W-1:0] bitSel;
    logic [`MCX_DATA_W-1:0] result;
    logic zero;
    logic writes;

    modport user (output op, output operand, output bitSel, input result, input zero, input writes);
    modport unit (input op, input operand, input bitSel, output result, output zero, output writes);
endinterface

// *** mcx_result_unit.sv ***
// combinational data path for clear, bit clear and invert
// assumes the operand byte is already read from data memory
`timescale 1ns/1ps
`include "mcx_params.svh"

module mcx_result_unit (
    mcx_res_if.unit res
);
    logic [`MCX_DATA_W-1:0] keepMask;

    // =================================================================
    // bit keep mask, one term per bit position
    genvar gi;
    generate
        for (gi = 0; gi < `MCX_DATA_W; gi++) begin : g_mask
            assign keepMask[gi] = (res.bitSel != `MCX_BIT_W'(gi));
        end
    endgenerate

    // =================================================================
    // result byte and write request per operation
    always_comb begin
        res.result = res.operand;
        res.writes = 1'b0;
        unique case (res.op)
            mcx_pkg::MCX_OP_CLEARBYTE: begin
                res.result = `MCX_BYTE_ZERO; // [RULE4]
                res.writes = 1'b1;
            end
            mcx_pkg::MCX_OP_CLEARBIT: begin
                res.result = res.operand & keepMask; // [RULE5]
                res.writes = 1'b1;
            end
            mcx_pkg::MCX_OP_INVERT: begin
                res.result = ~res.operand; // [RULE7]
                res.writes = 1'b1;
            end
            default: begin
                res.result = res.operand;
                res.writes = 1'b0;
            end
        endcase
    end

    // zero test on the value actually written
    assign res.zero = (res.result == `MCX_BYTE_ZERO); // [RULE9]
endmodule

// *** tb_mcu_call_clear_complement_exec.sv ***
// self-checking bench for mcx_exec: instruction issue plus axi4-lite registers
// assumes mcx_params.svh and mcx_pkg are compiled first; the watchdog is shortened
`timescale 1ns/1ps
`include "mcx_params.svh"

module tb_mcu_call_clear_complement_exec;
    // =========================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic instrValid = 1'b0, sleepReq = 1'b0;
    mcx_pkg::mcx_op_t instrOp = mcx_pkg::MCX_OP_CLEARBYTE;
    logic [7:0] instrAddr = 8'h0, instrOperand = 8'h0;
    logic [2:0] instrBit = 3'h0;
    logic [12:0] instrTarget = 13'h0, pcValue = 13'h0;
    logic instrReady, memWrEn, stackPush, pcLoad, zeroFlag, timeoutFlag, powerDownFlag;
    logic [7:0] memWrAddr, memWrData;
    logic [12:0] stackData, pcTarget;
    logic [15:0] watchdogCounter;
    // expectation notes: {zero, addr, data}, return addr, target, {resp, data}, resp
    logic [16:0] memQ[$];
    logic [12:0] stackQ[$], pcQ[$];
    logic [33:0] rQ[$];
    logic [1:0] bQ[$];
    logic [16:0] memE;
    logic [33:0] rE;
    logic zExp = 1'b0;
    logic pushSeen = 1'b0;
    int mismatches = 0;
    int numChecks = 0;

    always #25 clk = ~clk;

    // short terminal count keeps the timeout test to a few cycles
    mcx_exec #(.WDOG_TERMINAL(16'h0008)) dut (.clk(clk), .reset(reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .instrValid(instrValid), .instrOp(instrOp),
        .instrAddr(instrAddr), .instrBit(instrBit), .instrTarget(instrTarget),
        .instrOperand(instrOperand), .pcValue(pcValue), .sleepReq(sleepReq),
        .instrReady(instrReady), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
        .memWrData(memWrData), .stackPush(stackPush), .stackData(stackData), .pcLoad(pcLoad),
        .pcTarget(pcTarget), .zeroFlag(zeroFlag), .timeoutFlag(timeoutFlag),
        .powerDownFlag(powerDownFlag), .watchdogCounter(watchdogCounter));

    // =========================================================
    // comparison and verdict
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // =========================================================
    // drivers: each notes what it expects before the result can appear
    task automatic issue(input mcx_pkg::mcx_op_t op, input logic [7:0] a, input logic [2:0] b,
                         input logic [7:0] d, input logic [12:0] pc, input logic [12:0] t);
        int n;
        n = 0;
        instrOp <= op;
        instrAddr <= a;
        instrBit <= b;
        instrOperand <= d;
        pcValue <= pc;
        instrTarget <= t;
        instrValid <= 1'b1;
        case (op)
            mcx_pkg::MCX_OP_CALL: begin
                stackQ.push_back(pc + `MCX_PC_STEP);
                pcQ.push_back(t);
            end
            mcx_pkg::MCX_OP_CLEARBYTE: memQ.push_back({zExp, a, `MCX_BYTE_ZERO});
            mcx_pkg::MCX_OP_CLEARBIT: memQ.push_back({zExp, a, d & ~(`MCX_BIT_ONE << b)});
            mcx_pkg::MCX_OP_INVERT: begin
                zExp = (~d == 8'h00);
                memQ.push_back({zExp, a, ~d});
            end
            default: ;
        endcase
        // the offer stays up through the refused cycle after a call
        do begin
            @(posedge clk);
            n++;
        end while (instrReady !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
    endtask

    task automatic idle;
        instrValid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bQ.push_back(r);
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
    endtask

    task automatic axiRead(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rQ.push_back({r, d});
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
    endtask

    // =========================================================
    // monitor: oldest note against each result as it appears
    always @(posedge clk) begin
        if (!reset) begin
            if (memWrEn === 1'b1) begin
                if (memQ.size() == 0) compare("spare memWrEn", 0, 1);
                else begin
                    memE = memQ.pop_front();
                    compare("memWrAddr", memE[15:8], memWrAddr);
                    compare("memWrData", memE[7:0], memWrData);
                    compare("zeroFlag", memE[16], zeroFlag);
                    compare("instrReady at write", 1, instrReady);
                end
            end
            if (stackPush === 1'b1) begin
                if (stackQ.size() == 0) compare("spare stackPush", 0, 1);
                else compare("stackData", stackQ.pop_front(), stackData);
                compare("instrReady at push", 0, instrReady);
            end
            if (pcLoad === 1'b1) begin
                if (pcQ.size() == 0) compare("spare pcLoad", 0, 1);
                else compare("pcTarget", pcQ.pop_front(), pcTarget);
                compare("push before load", 1, pushSeen);
                compare("zeroFlag at load", zExp, zeroFlag);
            end
            if (s_axi_bvalid === 1'b1 && s_axi_bready) compare("bresp", bQ.pop_front(), s_axi_bresp);
            if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
                rE = rQ.pop_front();
                compare("rresp", rE[33:32], s_axi_rresp);
                compare("rdata", rE[31:0], s_axi_rdata);
            end
        end
        pushSeen <= (stackPush === 1'b1);
    end

    // =========================================================
    // main sequence
    initial begin
        logic [7:0] d;
        d = $urandom(51);
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // reset values, then an unmapped place and a read-only write
        axiRead(`MCX_REG_CONTROL, 0, `MCX_RESP_OKAY);
        axiRead(`MCX_REG_STATUS, 0, `MCX_RESP_OKAY);
        axiRead(`MCX_REG_RETADDR, 0, `MCX_RESP_OKAY);
        axiRead(4'h2, 0, `MCX_RESP_DECERR);
        axiWrite(`MCX_REG_STATUS, 32'hf, `MCX_RESP_OKAY);
        axiRead(`MCX_REG_STATUS, 0, `MCX_RESP_OKAY);
        $display("test registers done");
        // back-to-back calls, the second wrapping the program counter
        issue(mcx_pkg::MCX_OP_CALL, 8'h0, 3'h0, 8'h0, 13'h0123, 13'h0a5a);
        issue(mcx_pkg::MCX_OP_CALL, 8'h0, 3'h0, 8'h0, 13'h1fff, 13'h1555);
        idle();
        repeat (2) @(posedge clk);
        axiRead(`MCX_REG_RETADDR, 0, `MCX_RESP_OKAY);
        $display("test call done");
        // invert edges for the zero flag, then every bit position
        issue(mcx_pkg::MCX_OP_INVERT, 8'h10, 3'h0, 8'hff, 13'h0, 13'h0);
        issue(mcx_pkg::MCX_OP_CLEARBYTE, 8'h11, 3'h0, 8'h5a, 13'h0, 13'h0);
        issue(mcx_pkg::MCX_OP_INVERT, 8'h12, 3'h0, 8'h00, 13'h0, 13'h0);
        for (int i = 0; i < 8; i++) begin
            issue(mcx_pkg::MCX_OP_CLEARBIT, 8'h20 + i[7:0], i[2:0], 8'hff, 13'h0, 13'h0);
        end
        // random back-to-back mix of the one-cycle data ops
        for (int i = 0; i < 24; i++) begin
            d = $urandom;
            issue(mcx_pkg::mcx_op_t'(3'($urandom_range(3, 1)) == 3'h3 ? 3'h4 : 3'($urandom_range(2, 1))),
                  8'($urandom), 3'($urandom), d, 13'h0, 13'h0);
        end
        idle();
        repeat (3) @(posedge clk);
        $display("test data ops done");
        // watchdog wraps, sleep request, then the clear instruction
        axiWrite(`MCX_REG_CONTROL, 32'h1, `MCX_RESP_OKAY);
        for (int n = 0; n < 100 && timeoutFlag !== 1'b1; n++) @(posedge clk);
        sleepReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
        axiWrite(`MCX_REG_CONTROL, 32'h0, `MCX_RESP_OKAY);
        axiRead(`MCX_REG_STATUS, {28'h0, 3'b011, zExp}, `MCX_RESP_OKAY);
        issue(mcx_pkg::MCX_OP_CLEARWDOG, 8'h0, 3'h0, 8'h0, 13'h0, 13'h0);
        idle();
        compare("flags and counter", 0, {timeoutFlag, powerDownFlag, watchdogCounter});
        axiRead(`MCX_REG_WDOG, 0, `MCX_RESP_OKAY);
        axiRead(`MCX_REG_STATUS, {31'h0, zExp}, `MCX_RESP_OKAY);
        $display("test watchdog done");
        repeat (3) @(posedge clk);
        compare("notes left", 0, memQ.size() + stackQ.size() + pcQ.size() + rQ.size() + bQ.size());
        close_out();
    end

    // the whole sequence takes about a hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule
